// ### hw/dac_link_if.sv
// three-wire write link between host controller and dac port
`timescale 1ns/1ns
interface dac_link_if;
   logic cs_b;
   logic sclk;
   logic sdata;
   modport host (output cs_b, output sclk, output sdata);
   modport dev  (input cs_b, input sclk, input sdata);
endinterface

// ### hw/dac_link_pkg.sv
// shared constants and types for the dual dac serial write port
package dac_link_pkg;
   localparam int WORD_BITS  = 16;
   localparam int DATA_BITS  = 12;
   localparam int CNT_BITS   = 5;
   // word field positions
   localparam int SEL_HI_POS = 15;
   localparam int SPEED_POS  = 14;
   localparam int PWRDN_POS  = 13;
   localparam int SEL_LO_POS = 12;
   localparam int DATA_MSB   = 11;
   localparam int VREF_HI_POS = 1;
   localparam int VREF_LO_POS = 0;
   localparam logic [CNT_BITS-1:0] LAST_BIT_CNT = 5'h10;
   // values after reset
   localparam logic [DATA_BITS-1:0] LATCH_RST = 12'h000;
   localparam logic [WORD_BITS-1:0] WORD_RST  = 16'h0000;
   localparam logic [1:0]           VREF_RST  = 2'h0;
   // host clock divider: link clock half period in core cycles
   localparam logic [3:0] HALF_PERIOD_CYC = 4'h8;
   // destination codes {sel_hi, sel_lo}
   typedef enum logic [1:0] {
      DEST_B_AND_BUF = 2'h0,
      DEST_BUF_ONLY  = 2'h1,
      DEST_A_XFER_B  = 2'h2,
      DEST_CONTROL   = 2'h3
   } dest_t;
   typedef enum logic [1:0] {
      VREF_EXT_0   = 2'h0,
      VREF_INT_LOW = 2'h1,
      VREF_INT_HIGH = 2'h2,
      VREF_EXT_1   = 2'h3
   } vref_t;
endpackage

// ### hw/dac_port_dev.sv
// device end: shift register, destination latches and control register
//
// Notes on behaviour
// - cs low: shift msb first on sclk fall
// - sixteen bits, cs still low: transfer word
// - latches update on sixteenth sclk rise
// - word: sel_hi, speed, power, sel_lo, data
// - speed bit zero selects slow mode
// - power bit zero keeps normal operation
// - select 00: channel b and buffer
// - select 01: buffer only
// - select 10: channel a, buffer to b
// - select 11: control register
// - data field is the new code
// - host sends codes with low nibble zero
// - power-on reset clears all latches
// - byte hosts send two bytes, cs low
// - host drops cs before a transfer
// - control bits 1:0 choose the reference
// - a and b update on same edge
`timescale 1ns/1ns
module dac_port_dev
   import dac_link_pkg::*;
(
   input  wire logic                 RST_B_IN,
   dac_link_if.dev                   LINK,
   output logic [DATA_BITS-1:0]      CHAN_A_OUT,
   output logic [DATA_BITS-1:0]      CHAN_B_OUT,
   output logic [DATA_BITS-1:0]      HOLD_BUF_OUT,
   output logic                      FAST_MODE_OUT,
   output logic                      POWER_DOWN_OUT,
   output vref_t                     VREF_SEL_OUT
);
   import dac_link_pkg::*;

   // capture side: word and bit count run on the falling link clock; the
   // count has its own flop because deselect clears it asynchronously
   logic [WORD_BITS-1:0] shift_q, shift_d;
   logic [CNT_BITS-1:0]  cnt_q, cnt_d;
   logic                 frame_rst_b;

   // rise-edge update side
   typedef struct packed {
      logic [DATA_BITS-1:0] chan_a;
      logic [DATA_BITS-1:0] chan_b;
      logic [DATA_BITS-1:0] hold;
      logic                 fast;
      logic                 pwrdn;
      logic [1:0]           vref;
      logic                 done;
   } upd_t;

   upd_t                 upd_q, upd_d;
   logic                 word_end;
   dest_t                dest;
   logic [DATA_BITS-1:0] field;
   logic                 speed_bit;
   logic                 pwrdn_bit;
   logic [1:0]           vref_bits;

   // the shifter moves only while selected, so stray clocks are ignored
   always_comb begin
      shift_d = shift_q;
      cnt_d   = cnt_q;
      if (!LINK.cs_b && cnt_q != LAST_BIT_CNT) begin
         shift_d = {shift_q[WORD_BITS-2:0], LINK.sdata};
         cnt_d   = cnt_q + 5'h01;
      end
   end

   assign frame_rst_b = RST_B_IN && !LINK.cs_b;

   always_ff @(negedge LINK.sclk or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         shift_q <= WORD_RST;
      end else begin
         shift_q <= shift_d;
      end
   end

   // deselect restarts the count at once, so a new frame always starts at bit 15
   always_ff @(negedge LINK.sclk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // fields of the received word
   assign dest      = dest_t'({shift_q[SEL_HI_POS], shift_q[SEL_LO_POS]});
   assign field     = shift_q[DATA_MSB:0];
   assign speed_bit = shift_q[SPEED_POS];
   assign pwrdn_bit = shift_q[PWRDN_POS];
   assign vref_bits = shift_q[VREF_HI_POS:VREF_LO_POS];

   // full word seen; a short frame ended by cs rise is never committed,
   // since a partial word has its select bits misplaced
   assign word_end = (cnt_q == LAST_BIT_CNT) && !LINK.cs_b;

   always_comb begin
      upd_d = upd_q;
      upd_d.done = word_end;
      if (word_end && !upd_q.done) begin
         unique case (dest)
            DEST_B_AND_BUF: begin
               upd_d.chan_b = field;
               upd_d.hold   = field;
            end
            DEST_BUF_ONLY: begin
               upd_d.hold = field;
            end
            DEST_A_XFER_B: begin
               upd_d.chan_a = field;
               upd_d.chan_b = upd_q.hold;
            end
            DEST_CONTROL: begin
               upd_d.vref = vref_bits;
            end
         endcase
         upd_d.fast  = speed_bit;
         upd_d.pwrdn = pwrdn_bit;
      end
   end

   always_ff @(posedge LINK.sclk or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         upd_q <= '{chan_a: LATCH_RST,
                    chan_b: LATCH_RST,
                    hold:   LATCH_RST,
                    fast:   1'b0,
                    pwrdn:  1'b0,
                    vref:   VREF_RST,
                    done:   1'b0};
      end else begin
         upd_q <= upd_d;
      end
   end

   assign CHAN_A_OUT     = upd_q.chan_a;
   assign CHAN_B_OUT     = upd_q.chan_b;
   assign HOLD_BUF_OUT   = upd_q.hold;
   assign FAST_MODE_OUT  = upd_q.fast;
   assign POWER_DOWN_OUT = upd_q.pwrdn;
   assign VREF_SEL_OUT   = vref_t'(upd_q.vref);
endmodule // dac_port_dev

// ### hw/dac_port_host.sv
// host end: ahb-lite slave with a word register, drives the three-wire link
`timescale 1ns/1ns
module dac_port_host
   import dac_link_pkg::*;
(
   input  wire logic         CORE_CLK_IN,
   input  wire logic         RST_B_IN,
   input  wire logic         HSEL_IN,
   input  wire logic [31:0]  HADDR_IN,
   input  wire logic [1:0]   HTRANS_IN,
   input  wire logic         HWRITE_IN,
   input  wire logic [2:0]   HSIZE_IN,
   input  wire logic [31:0]  HWDATA_IN,
   input  wire logic         HREADY_IN,
   output logic [31:0]       HRDATA_OUT,
   output logic              HREADYOUT_OUT,
   output logic              HRESP_OUT,
   dac_link_if.host          LINK
);
   import dac_link_pkg::*;

   localparam logic [7:0]  WORD_OFS   = 8'h00;
   localparam logic [7:0]  STATUS_OFS = 8'h04;

   typedef enum logic [1:0] {IDLE, SETUP, SHIFT, FINISH} st_t;

   typedef struct packed {
      st_t                  st;
      logic [WORD_BITS-1:0] word;
      logic [WORD_BITS-1:0] last;
      logic [CNT_BITS-1:0]  bits;
      logic [3:0]           div;
      logic                 sclk;
      logic                 cs_b;
      logic                 wr_ph;
      logic [7:0]           addr;
      logic [31:0]          rdata;
   } state_t;

   state_t s_q, s_d;
   logic   busy;

   assign busy = (s_q.st != IDLE);

   always_comb begin
      s_d = s_q;
      // data phase of a write: the word register starts a frame
      if (s_q.wr_ph && s_q.addr == WORD_OFS && !busy) begin
         s_d.word = HWDATA_IN[WORD_BITS-1:0];
         s_d.last = HWDATA_IN[WORD_BITS-1:0];
         s_d.st   = SETUP;
         s_d.cs_b = 1'b0;
         s_d.div  = '0;
         s_d.bits = '0;
      end
      s_d.wr_ph = 1'b0;
      if (HSEL_IN && HREADY_IN && HTRANS_IN[1]) begin
         s_d.wr_ph = HWRITE_IN;
         s_d.addr  = HADDR_IN[7:0];
         unique case (HADDR_IN[7:0])
            WORD_OFS:   s_d.rdata = {16'h0000, s_q.last};
            STATUS_OFS: s_d.rdata = {31'h00000000, busy};
            default:    s_d.rdata = 32'h00000000;
         endcase
      end
      // link clock made by division; one whole frame of 16 bits
      if (busy) begin
         s_d.div = s_q.div + 4'h1;
         if (s_q.div == HALF_PERIOD_CYC - 4'h1) begin
            s_d.div = '0;
            unique case (s_q.st)
               SETUP: s_d.st = SHIFT;
               SHIFT: begin
                  if (s_q.sclk && s_q.bits == LAST_BIT_CNT) begin
                     // sixteenth rise done: deselect with the clock left high,
                     // so no seventeenth fall and the next frame starts on a fall
                     s_d.cs_b = 1'b1;
                     s_d.st   = FINISH;
                  end else begin
                     s_d.sclk = ~s_q.sclk;
                     if (!s_q.sclk) begin
                        // data changes on rise, device samples on fall
                        s_d.word = {s_q.word[WORD_BITS-2:0], 1'b0};
                        s_d.bits = s_q.bits + 5'h01;
                     end
                  end
               end
               FINISH: begin
                  // one half period of deselect before the next frame may start
                  s_d.st = IDLE;
               end
               default: s_d.st = IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         s_q <= '{st: IDLE, word: WORD_RST, last: WORD_RST, bits: '0, div: '0,
                  sclk: 1'b1, cs_b: 1'b1, wr_ph: 1'b0, addr: 8'h00, rdata: 32'h00000000};
      end else begin
         s_q <= s_d;
      end
   end

   // first bit is put out when the word is loaded; sclk idles high so the
   // sixteenth rise follows the sixteenth fall before cs is raised
   assign LINK.sclk     = s_q.sclk;
   assign LINK.cs_b     = s_q.cs_b;
   assign LINK.sdata    = s_q.word[WORD_BITS-1];
   assign HRDATA_OUT    = s_q.rdata;
   assign HREADYOUT_OUT = 1'b1;
   assign HRESP_OUT     = 1'b0;
endmodule // dac_port_host

// ### sim/dac_link_checker.sv
// link and device output checks
`timescale 1ns/1ns
module dac_link_checker
   import dac_link_pkg::*;
(
   input wire logic                 CORE_CLK_IN,
   input wire logic                 RST_B_IN,
   input wire logic                 cs_b,
   input wire logic                 sclk,
   input wire logic                 sdata,
   input wire logic [DATA_BITS-1:0] CHAN_A_OUT,
   input wire logic [DATA_BITS-1:0] CHAN_B_OUT,
   input wire logic [DATA_BITS-1:0] HOLD_BUF_OUT,
   input wire logic                 FAST_MODE_OUT,
   input wire logic                 POWER_DOWN_OUT,
   input wire vref_t                VREF_SEL_OUT
);
   logic       sclk_q;
   logic [4:0] falls_q;
   // falls seen in the core domain; link is slow enough to sample
   always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         sclk_q <= 1'b1;
         falls_q <= 5'h00;
      end else begin
         sclk_q <= sclk;
         if (cs_b) falls_q <= 5'h00;
         else if (sclk_q && !sclk) falls_q <= falls_q + 5'h01;
      end
   end
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   sequence s_open; $fell(cs_b); endsequence
   sequence s_close; $rose(cs_b); endsequence
   property p_len; s_close |-> falls_q == LAST_BIT_CNT; endproperty
   a_len: assert property (p_len) else $error("frame not 16 bits");
   property p_span; s_open |-> ##[200:400] s_close; endproperty
   a_span: assert property (p_span) else $error("frame did not close");
   property p_idle; cs_b |-> sclk; endproperty
   a_idle: assert property (p_idle) else $error("link clock moved while idle");
   property p_hold; $fell(sclk) |-> $stable(sdata) [*4]; endproperty
   a_hold: assert property (p_hold) else $error("data moved at falling edge");
   property p_upd; $changed({CHAN_A_OUT, CHAN_B_OUT, HOLD_BUF_OUT}) |-> $rose(sclk) && !cs_b; endproperty
   a_upd: assert property (p_upd) else $error("latch changed off a rise");
   property p_ctl; $changed({FAST_MODE_OUT, POWER_DOWN_OUT, VREF_SEL_OUT}) |-> $rose(sclk); endproperty
   a_ctl: assert property (p_ctl) else $error("control changed off a rise");
   property p_frz; cs_b |-> $stable(CHAN_A_OUT) && $stable(CHAN_B_OUT); endproperty
   a_frz: assert property (p_frz) else $error("output moved while deselected");
   property p_rst; $rose(RST_B_IN) |-> {CHAN_A_OUT, CHAN_B_OUT, HOLD_BUF_OUT} == 36'h0; endproperty
   a_rst: assert property (p_rst) else $error("latch not clear after reset");
endmodule // dac_link_checker

// ### sim/dual_dac_serial_write_port_bench.sv
// bench: ahb writes to the host end, checks link and device outputs
`timescale 1ns/1ns
module dual_dac_serial_write_port_bench;
   import dac_link_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hrdata;
   logic [31:0] rdat;
   logic        hready;
   logic [15:0] wire_q = 16'h0;
   logic [11:0] ca, cb, hb;
   logic        fast, pd;
   vref_t       vref;
   int          err_count = 0;
   int          n_compared = 0;
   always #4 clk = ~clk;
   dac_link_if dac_link_if_i ();
   dac_port_host dac_port_host_i (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(1'b1), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
      .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(), .LINK(dac_link_if_i));
   dac_port_dev dac_port_dev_i (.RST_B_IN(rst_b), .LINK(dac_link_if_i), .CHAN_A_OUT(ca), .CHAN_B_OUT(cb),
      .HOLD_BUF_OUT(hb), .FAST_MODE_OUT(fast), .POWER_DOWN_OUT(pd), .VREF_SEL_OUT(vref));
   dac_link_checker dac_link_checker_i (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .cs_b(dac_link_if_i.cs_b),
      .sclk(dac_link_if_i.sclk), .sdata(dac_link_if_i.sdata), .CHAN_A_OUT(ca), .CHAN_B_OUT(cb),
      .HOLD_BUF_OUT(hb), .FAST_MODE_OUT(fast), .POWER_DOWN_OUT(pd), .VREF_SEL_OUT(vref));
   // own shifter on the wire, independent of the device
   always @(negedge dac_link_if_i.sclk) if (!dac_link_if_i.cs_b) wire_q <= {wire_q[14:0], dac_link_if_i.sdata};
   task automatic close_out();
      $display("compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // bounded waits: a hang counts as a mismatch and ends the run
   task automatic wait_on(input logic [1:0] what, input logic v);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((what == 2'h0 ? hready : dac_link_if_i.cs_b) !== v && n < 1000);
      if (n >= 1000) begin
         err_count++;
         close_out();
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      wait_on(2'h0, 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      wait_on(2'h0, 1'b1);
      rdat = hrdata;
   endtask
   task automatic send(input logic [15:0] w);
      int n;
      n = 0;
      ahb(1'b1, 32'h0, {16'h0, w});
      wait_on(2'h1, 1'b0);
      wait_on(2'h1, 1'b1);
      chk("wire word", {16'h0, w}, {16'h0, wire_q});
      // the port stays busy a while after deselect and ignores a word then
      do begin
         ahb(1'b0, 32'h4, 32'h0);
         n++;
      end while (rdat[0] !== 1'b0 && n < 100);
      if (n >= 100) begin
         err_count++;
         close_out();
      end
   endtask
   task automatic outs(input logic [11:0] a, input logic [11:0] b, input logic [11:0] h);
      chk("latches", {a, b, h}, {ca, cb, hb});
   endtask
   initial begin
      rst_b <= 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      outs(12'h000, 12'h000, 12'h000);
      chk("control", 32'h0, {fast, pd, vref});
      send(16'h1AB0);
      outs(12'h000, 12'h000, 12'hAB0);
      send(16'h0120);
      outs(12'h000, 12'h120, 12'h120);
      send(16'h1550);
      send(16'h8FF0);
      outs(12'hFF0, 12'h550, 12'h550);
      for (int v = 0; v < 4; v++) begin
         send(16'hD000 | 16'(v));
         chk("control", {28'h0, 2'b10, 2'(v)}, {fast, pd, vref});
      end
      send(16'hB000);
      chk("control", 32'h4, {fast, pd, vref});
      send(16'h9001);
      chk("control", 32'h1, {fast, pd, vref});
      outs(12'hFF0, 12'h550, 12'h550);
      ahb(1'b0, 32'h0, 32'h0);
      chk("word reg", 32'h9001, rdat);
      ahb(1'b0, 32'h4, 32'h0);
      chk("status", 32'h0, rdat);
      ahb(1'b0, 32'h8, 32'h0);
      chk("unmapped", 32'h0, rdat);
      close_out();
   end
endmodule // dual_dac_serial_write_port_bench
